// ---- src/ssx_alu.sv ----
// Subtract and nibble-exchange datapath
`timescale 1ns/100ps
`default_nettype none
module ssx_alu
  import ssx_pkg::*;
(
  input wire logic [7:0] fval,
  input wire logic [7:0] acc,
  output ssx_alu_t sub_out,
  output logic [7:0] swp_out
);

  logic [8:0] diff;
  logic [4:0] ldiff;

  // Two's complement: f + ~acc + 1; carry out means no borrow
  always_comb
  begin
    diff = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
    ldiff = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    sub_out.res = diff[7:0];
    sub_out.borrow_inv = diff[8];
    sub_out.nib_borrow = ldiff[4];
    sub_out.null_res = (diff[7:0] == 8'h00);
  end

  // Nibble exchange
  assign swp_out = {fval[3:0], fval[7:4]};

endmodule
`default_nettype wire

// ---- src/ssx_core.sv ----
// Execute stage for subtract, nibble exchange and direction-register load
//
// Overview of operation
// - Opcode 000010 computes file minus accumulator.
// - Destination bit 1 writes file, 0 accumulator.
// - No borrow sets borrow-inverse; zero sets null.
// - Borrow clears borrow-inverse; wrapped result stored.
// - Opcode 001110 exchanges nibbles; flags untouched.
// - Exchange result to accumulator or file.
// - Direction load copies accumulator, flags untouched.
// - Direction registers also reachable as addressed registers.
`timescale 1ns/100ps
`default_nettype none
module ssx_core
  import ssx_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire logic [IW_W-1:0] INSTR_WORD,
  input wire logic [7:0] OPERAND,
  input wire logic [RA_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic FILE_WE,
  output logic [6:0] FILE_ADDR,
  output logic [7:0] FILE_WDATA,
  output logic INSTR_DONE,
  output logic [7:0] ACC,
  output logic BORROW_INV,
  output logic NIBBLE_BORROW,
  output logic RESULT_NULL,
  output logic [7:0] DIRECTION5,
  output logic [7:0] DIRECTION6,
  output logic [7:0] DIRECTION7
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath

  ssx_dec_t dec; // Decoded current word
  ssx_alu_t sub_r; // Subtraction result and flags
  logic [7:0] swp_r; // Exchanged operand
  logic [7:0] acc_ff; // Accumulator
  logic [2:0] flags_ff; // Borrow-inverse, nibble borrow, null
  logic [7:0] dir_ff [3]; // Port direction registers
  logic [7:0] rdata_ff; // Read data, valid one cycle after strobe
  logic fwe_ff; // File write strobe
  logic [6:0] faddr_ff; // File write address
  logic [7:0] fwdata_ff; // File write data
  logic done_ff; // Completion pulse

  ssx_decode u_dec
  (
    .valid(INSTR_VALID),
    .word(INSTR_WORD),
    .dec(dec)
  );

  // OPERAND carries the addressed file register in the same cycle
  ssx_alu u_alu
  (
    .fval(OPERAND),
    .acc(acc_ff),
    .sub_out(sub_r),
    .swp_out(swp_r)
  );

  // True when the bus writes a given register this cycle
  function automatic logic bus_hit(input logic wr, input logic [3:0] a,
                                   input logic [3:0] ofs);
    bus_hit = wr && (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // File register write-back

  // One pulse per write-back; no stall, so back-to-back words are fine
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      fwe_ff <= 1'b0;
      faddr_ff <= 7'h00;
      fwdata_ff <= 8'h00;
    end
    else
    begin
      fwe_ff <= (dec.sub || dec.swp) && dec.to_file;
      faddr_ff <= dec.faddr;
      if (dec.sub)
      begin
        fwdata_ff <= sub_r.res;
      end
      else
      begin
        fwdata_ff <= swp_r;
      end
    end
  end

  // Completion follows every recognised word by exactly one edge
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= dec.sub || dec.swp || dec.dirld;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator

  // Instruction wins over a bus write in the same cycle, so the
  // program's view stays consistent
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      acc_ff <= ACC_RST;
    end
    else if (dec.sub && !dec.to_file)
    begin
      acc_ff <= sub_r.res;
    end
    else if (dec.swp && !dec.to_file)
    begin
      acc_ff <= swp_r;
    end
    else if (bus_hit(REG_WR, REG_ADDR, RA_ACC))
    begin
      acc_ff <= REG_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Only subtraction and a status-register bus write touch the flags; exchange and load leave them
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      flags_ff <= FLAGS_RST;
    end
    else if (dec.sub)
    begin
      flags_ff[ST_BORROW_INV] <= sub_r.borrow_inv;
      flags_ff[ST_NIB_BORROW] <= sub_r.nib_borrow;
      flags_ff[ST_NULL] <= sub_r.null_res;
    end
    else if (bus_hit(REG_WR, REG_ADDR, RA_STATUS))
    begin
      flags_ff <= REG_WDATA[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction registers

  // Legacy load or plain register write; the load takes priority
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < 3; i++)
      begin
        dir_ff[i] <= DIR_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (dec.dirld && (dec.dsel == 2'(i)))
        begin
          dir_ff[i] <= acc_ff;
        end
        else if (bus_hit(REG_WR, REG_ADDR, 4'(RA_DIR5 + 4'(i))))
        begin
          dir_ff[i] <= REG_WDATA;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  // Data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_ff <= 8'h00;
    end
    else if (!REG_RD)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      unique case (REG_ADDR)
        RA_ACC: rdata_ff <= acc_ff;
        RA_STATUS: rdata_ff <= {5'h00, flags_ff};
        RA_DIR5: rdata_ff <= dir_ff[0];
        RA_DIR6: rdata_ff <= dir_ff[1];
        RA_DIR7: rdata_ff <= dir_ff[2];
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign REG_RDATA = rdata_ff;
  assign FILE_WE = fwe_ff;
  assign FILE_ADDR = faddr_ff;
  assign FILE_WDATA = fwdata_ff;
  assign INSTR_DONE = done_ff;
  assign ACC = acc_ff;
  assign BORROW_INV = flags_ff[ST_BORROW_INV];
  assign NIBBLE_BORROW = flags_ff[ST_NIB_BORROW];
  assign RESULT_NULL = flags_ff[ST_NULL];
  assign DIRECTION5 = dir_ff[0];
  assign DIRECTION6 = dir_ff[1];
  assign DIRECTION7 = dir_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  logic [7:0] swp_in; // Exchanged operand seen at the ports
  logic st_wr; // Bus write to the status register
  assign swp_in = {OPERAND[3:0], OPERAND[7:4]};
  assign st_wr = REG_WR && (REG_ADDR == RA_STATUS);

  sub_result_a: assert property (
    dec.sub && dec.to_file |=> FILE_WE
      && (FILE_WDATA == $past(OPERAND) - $past(ACC)))
    else $error("subtract result wrong");

  sub_to_acc_a: assert property (
    dec.sub && !dec.to_file |=> !FILE_WE
      && (ACC == $past(OPERAND) - $past(ACC)))
    else $error("subtract to accumulator wrong");

  no_borrow_a: assert property (
    dec.sub && (OPERAND >= ACC) |=> BORROW_INV
      && (RESULT_NULL == ($past(OPERAND) == $past(ACC))))
    else $error("no-borrow flags wrong");

  borrow_a: assert property (
    dec.sub && (OPERAND < ACC) |=> !BORROW_INV && !RESULT_NULL)
    else $error("borrow flags wrong");

  swap_flags_a: assert property (
    dec.swp && !st_wr |=> $stable({BORROW_INV, NIBBLE_BORROW, RESULT_NULL}))
    else $error("exchange altered flags");

  // The next word may already differ, so only sampled history is used
  swap_dest_a: assert property (
    dec.swp |=> ($past(dec.to_file)
      ? (FILE_WE && FILE_WDATA == $past(swp_in)
         && FILE_ADDR == $past(dec.faddr))
      : (!FILE_WE && ACC == $past(swp_in))))
    else $error("exchange destination wrong");

  // Writing the file register must leave the accumulator alone
  sub_acc_keep_a: assert property (
    dec.sub && dec.to_file && !(REG_WR && (REG_ADDR == RA_ACC))
      |=> $stable(ACC))
    else $error("subtract to file altered accumulator");

  // Bus writes reach a direction register when no load competes
  dir_write_a: assert property (
    REG_WR && (REG_ADDR == RA_DIR6) && !dec.dirld
      |=> DIRECTION6 == $past(REG_WDATA))
    else $error("direction write lost");

  dir_load_a: assert property (
    dec.dirld && (INSTR_WORD[2:0] == DIRSEL_MIN) && !st_wr
      |=> (DIRECTION5 == $past(ACC)) && $stable(BORROW_INV))
    else $error("direction load wrong");

  dir_read_a: assert property (
    REG_RD && (REG_ADDR == RA_DIR6) |=> REG_RDATA == $past(DIRECTION6))
    else $error("direction read wrong");

  one_cycle_a: assert property (
    (dec.sub || dec.swp || dec.dirld) |=> INSTR_DONE)
    else $error("instruction not done in one cycle");

endmodule
`default_nettype wire

// ---- src/ssx_decode.sv ----
// Instruction decoder for subtract, nibble exchange and direction load
`timescale 1ns/100ps
`default_nettype none
module ssx_decode
  import ssx_pkg::*;
(
  input wire logic valid,
  input wire logic [IW_W-1:0] word,
  output ssx_dec_t dec
);

  // Pure decode; the direction-load field must fall in its legal range
  always_comb
  begin
    dec = '0;
    dec.to_file = word[DSEL_BIT];
    dec.faddr = word[FADDR_HI:0];
    dec.dsel = 2'(word[2:0] - DIRSEL_MIN);
    dec.sub = valid && (word[OPC_HI:OPC_LO] == OPC_SUB);
    dec.swp = valid && (word[OPC_HI:OPC_LO] == OPC_SWAP);
    // Bit 3 must be zero; selects outside the range are ignored
    dec.dirld = valid && (word[OPC_HI:4] == OPC_DIRLD) && !word[3]
                && (word[2:0] >= DIRSEL_MIN) && (word[2:0] <= DIRSEL_MAX);
  end

endmodule
`default_nettype wire

// ---- src/ssx_pkg.sv ----
// Shared constants, encodings and carrier types of the decode/execute block
package ssx_pkg;

  // Instruction word layout
  localparam int IW_W = 14;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DSEL_BIT = 7;
  localparam int FADDR_HI = 6;

  // Opcode patterns in the top six bits
  localparam logic [5:0] OPC_SUB = 6'h02;
  localparam logic [5:0] OPC_SWAP = 6'h0E;
  // Direction-load: upper ten bits fixed, bit 3 zero, low three select
  localparam logic [9:0] OPC_DIRLD = 10'h006;
  localparam logic [2:0] DIRSEL_MIN = 3'h5;
  localparam logic [2:0] DIRSEL_MAX = 3'h7;

  // Register port map
  localparam int RA_W = 4;
  localparam logic [3:0] RA_ACC = 4'h0;
  localparam logic [3:0] RA_STATUS = 4'h1;
  localparam logic [3:0] RA_DIR5 = 4'h5;
  localparam logic [3:0] RA_DIR6 = 4'h6;
  localparam logic [3:0] RA_DIR7 = 4'h7;

  // Status register fields
  localparam int ST_BORROW_INV = 0;
  localparam int ST_NIB_BORROW = 1;
  localparam int ST_NULL = 2;

  // Values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  // Decoded instruction
  typedef struct packed {
    logic sub;
    logic swp;
    logic dirld;
    logic to_file;
    logic [6:0] faddr;
    logic [1:0] dsel;
  } ssx_dec_t;

  // Arithmetic result with the flags it produces
  typedef struct packed {
    logic [7:0] res;
    logic borrow_inv;
    logic nib_borrow;
    logic null_res;
  } ssx_alu_t;

endpackage

// ---- verif/ssx_core_bench.sv ----
// Self-checking bench for the subtract, exchange and direction-load block
`timescale 1ns/100ps
`default_nettype none
module ssx_core_bench;
  import ssx_pkg::*;
  logic MCLK;
  logic RST;
  logic INSTR_VALID;
  logic [IW_W-1:0] INSTR_WORD;
  logic [7:0] OPERAND;
  logic [RA_W-1:0] REG_ADDR;
  logic [7:0] REG_WDATA;
  logic REG_WR;
  logic REG_RD;
  logic [7:0] REG_RDATA;
  logic FILE_WE;
  logic [6:0] FILE_ADDR;
  logic [7:0] FILE_WDATA;
  logic INSTR_DONE;
  logic [7:0] ACC;
  logic BORROW_INV;
  logic NIBBLE_BORROW;
  logic RESULT_NULL;
  logic [7:0] DIRECTION5;
  logic [7:0] DIRECTION6;
  logic [7:0] DIRECTION7;
  int miscompares;
  int n_checks;

  ssx_core ssx_core_inst (.MCLK(MCLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .OPERAND(OPERAND), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .FILE_WE(FILE_WE), .FILE_ADDR(FILE_ADDR),
    .FILE_WDATA(FILE_WDATA), .INSTR_DONE(INSTR_DONE), .ACC(ACC),
    .BORROW_INV(BORROW_INV), .NIBBLE_BORROW(NIBBLE_BORROW),
    .RESULT_NULL(RESULT_NULL), .DIRECTION5(DIRECTION5),
    .DIRECTION6(DIRECTION6), .DIRECTION7(DIRECTION7));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, reporting and bus tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  // One word for one cycle; results are looked at just after the next edge
  task automatic exec(input logic [IW_W-1:0] w, input logic [7:0] op);
    @(posedge MCLK);
    INSTR_VALID <= 1'b1;
    INSTR_WORD <= w;
    OPERAND <= op;
    @(posedge MCLK);
    INSTR_VALID <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sub_case(input logic d, input logic [7:0] f,
                          input logic [7:0] a);
    logic [7:0] res;
    res = f - a;
    reg_wr(RA_ACC, a);
    exec({OPC_SUB, d, 7'h2A}, f);
    chk(INSTR_DONE, 8'h01);
    chk(FILE_WE, {7'h00, d});
    chk(ACC, d ? a : res);
    if (d)
    begin
      chk(FILE_ADDR, 8'h2A);
      chk(FILE_WDATA, res);
    end
    chk(BORROW_INV, {7'h00, f >= a});
    chk(NIBBLE_BORROW, {7'h00, f[3:0] >= a[3:0]});
    chk(RESULT_NULL, {7'h00, res == 8'h00});
    @(posedge MCLK);
    #1 chk(INSTR_DONE | FILE_WE, 8'h00);
  endtask

  task automatic swap_case(input logic d);
    // Flags preset through the status register must survive the exchange
    reg_wr(RA_STATUS, 8'h05);
    reg_wr(RA_ACC, 8'h11);
    exec({OPC_SWAP, d, 7'h13}, 8'hA5);
    chk(ACC, d ? 8'h11 : 8'h5A);
    chk(FILE_WE, {7'h00, d});
    if (d)
    begin
      chk(FILE_WDATA, 8'h5A);
      chk(FILE_ADDR, 8'h13);
    end
    chk({BORROW_INV, NIBBLE_BORROW, RESULT_NULL}, 8'h05);
  endtask

  task automatic dir_case();
    logic [7:0] exp [5:7];
    logic [7:0] rd;
    exp = '{8'hFF, 8'hFF, 8'hFF};
    for (int s = 4; s <= 7; s++)
    begin
      reg_wr(RA_ACC, 8'h30 + s[7:0]);
      reg_wr(RA_STATUS, 8'h02);
      exec({OPC_DIRLD, 1'b0, s[2:0]}, 8'h00);
      chk(INSTR_DONE, {7'h00, s >= 5});
      if (s >= 5)
        exp[s] = 8'h30 + s[7:0];
      chk(DIRECTION5, exp[5]);
      chk(DIRECTION6, exp[6]);
      chk(DIRECTION7, exp[7]);
      chk({BORROW_INV, NIBBLE_BORROW, RESULT_NULL}, 8'h02);
    end
    // Same registers through the register port
    reg_wr(RA_DIR6, 8'hC3);
    reg_rd(RA_DIR6, rd);
    chk(rd, 8'hC3);
    // Read data stand for one cycle only, then fall back to zero
    @(posedge MCLK);
    #1 chk(REG_RDATA, 8'h00);
    reg_rd(RA_DIR7, rd);
    chk(rd, 8'h37);
    reg_rd(4'h9, rd);
    chk(rd, 8'h00);
  endtask

  task automatic b2b_case();
    // Second word must see the accumulator left by the first
    reg_wr(RA_ACC, 8'h10);
    @(posedge MCLK);
    INSTR_VALID <= 1'b1;
    INSTR_WORD <= {OPC_SUB, 1'b0, 7'h01};
    OPERAND <= 8'h30;
    @(posedge MCLK);
    OPERAND <= 8'h25;
    #1 chk(ACC, 8'h20);
    @(posedge MCLK);
    INSTR_VALID <= 1'b0;
    #1 chk(ACC, 8'h05);
    chk(INSTR_DONE, 8'h01);
    exec(14'h0500, 8'h77);
    chk(INSTR_DONE, 8'h00);
  endtask

  task automatic reset_case();
    // A reset in mid-run must bring every register back to its start value
    reg_wr(RA_ACC, 8'h55);
    reg_wr(RA_DIR5, 8'h0F);
    @(posedge MCLK);
    RST <= 1'b1;
    @(posedge MCLK);
    RST <= 1'b0;
    #1 chk(ACC, ACC_RST);
    chk(DIRECTION5, DIR_RST);
    chk({BORROW_INV, NIBBLE_BORROW, RESULT_NULL}, {5'h00, FLAGS_RST});
    chk({6'h00, INSTR_DONE, FILE_WE}, 8'h00);
    chk(REG_RDATA, 8'h00);
    // The block must work again from the first edge after release
    sub_case(1'b0, 8'h09, 8'h04);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    miscompares = 0;
    n_checks = 0;
    RST = 1'b1;
    {INSTR_VALID, REG_WR, REG_RD} = 3'h0;
    INSTR_WORD = '0;
    OPERAND = 8'h00;
    REG_ADDR = 4'h0;
    REG_WDATA = 8'h00;
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    #1 chk(ACC, ACC_RST);
    chk({BORROW_INV, NIBBLE_BORROW, RESULT_NULL}, 8'h00);
    chk(DIRECTION5 & DIRECTION6 & DIRECTION7, DIR_RST);
    sub_case(1'b1, 8'h03, 8'h02);
    sub_case(1'b1, 8'h02, 8'h02);
    sub_case(1'b1, 8'h01, 8'h02);
    sub_case(1'b0, 8'h1F, 8'h0E);
    sub_case(1'b0, 8'h40, 8'h41);
    swap_case(1'b0);
    swap_case(1'b1);
    dir_case();
    b2b_case();
    reset_case();
    close_out();
  end

  // Watchdog against a stuck run
  initial
  begin
    repeat (5000) @(posedge MCLK);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
